// ==== vfpwm_three_phase.v ====
`include "vfpwm_consts.vh"

module vfpwm_three_phase #(
   parameter STEP_THRESHOLD = (`VFPWM_CLOCK_HZ / (`VFPWM_TABLE_ENTRIES * `VFPWM_MAX_MOTOR_HZ))
      * `VFPWM_SPEED_FULL_SCALE,
   parameter RESAMPLE_CYCLES = (`VFPWM_RESAMPLE_TIME_NS / 1000) * (`VFPWM_CLOCK_HZ / 1000000)
)(
   input wire clock,
   input wire sys_rst,
   input wire clockEnable,
   input wire [2:0] regAddr,
   input wire [15:0] regWriteData,
   input wire regWrite,
   input wire regRead,
   output reg [15:0] regReadData,
   input wire [9:0] speedSample,
   input wire driverFault_n,
   output wire phaseADrive,
   output wire phaseBDrive,
   output reg phaseCDrive,
   output wire driverEnable,
   output reg directionIndicator
);

   // ****************************************************************
   // Sine table.
   // ****************************************************************
   function [7:0] sineSample;
      input integer idx;
      reg [8:0] value;
      integer k;
      begin
         if (idx < 12)
            k = idx;
         else if (idx < 24)
            k = 24 - idx;
         else if (idx < 36)
            k = idx - 24;
         else
            k = 48 - idx;
         case (k)
            0: value = 9'h000;
            1: value = 9'h011;
            2: value = 9'h021;
            3: value = 9'h031;
            4: value = 9'h040;
            5: value = 9'h04E;
            6: value = 9'h05B;
            7: value = 9'h066;
            8: value = 9'h06F;
            9: value = 9'h076;
            10: value = 9'h07C;
            11: value = 9'h07F;
            default: value = 9'h080;
         endcase
         if (idx < 24)
            value = 9'h080 + value;
         else
            value = 9'h080 - value;
         if (value > 9'h0FF)
            sineSample = 8'hFF;
         else
            sineSample = value[7:0];
      end
   endfunction

   wire [7:0] sineTable [0:`VFPWM_TABLE_ENTRIES-1];
   genvar g;
   generate
      for (g = 0; g < `VFPWM_TABLE_ENTRIES; g = g + 1)
      begin : gTable
         assign sineTable[g] = sineSample(g);
      end
   endgenerate

   // ****************************************************************
   // Pin synchronisers.
   // ****************************************************************
   reg [9:0] speedMeta;
   reg [9:0] speedSync;
   reg faultMeta_n;
   reg faultSync_n;

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         speedMeta <= 10'h000;
         speedSync <= 10'h000;
         faultMeta_n <= 1'b1;
         faultSync_n <= 1'b1;
      end
      else if (clockEnable)
      begin
         speedMeta <= speedSample;
         speedSync <= speedMeta;
         faultMeta_n <= driverFault_n;
         faultSync_n <= faultMeta_n;
      end
   end

   // ****************************************************************
   // Speed reference resampling.
   // ****************************************************************
   reg [14:0] resampleCount;
   reg [9:0] speedRef;
   wire resampleTick = (resampleCount == RESAMPLE_CYCLES - 1);

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         resampleCount <= 15'h0000;
         speedRef <= 10'h000;
      end
      else if (clockEnable)
      begin
         if (resampleTick)
         begin
            resampleCount <= 15'h0000;
            speedRef <= speedSync;
         end
         else
            resampleCount <= resampleCount + 15'h0001;
      end
   end

   // ****************************************************************
   // Table step timer.
   // ****************************************************************
   // The accumulator adds the speed reference each cycle, so the step
   // period is the threshold divided by the speed; zero speed never steps.
   localparam [22:0] STEP_LIMIT = STEP_THRESHOLD[22:0];
   reg [22:0] stepAccum;
   wire [22:0] stepSum = stepAccum + {13'h0000, speedRef};
   wire stepTick = (stepSum >= STEP_LIMIT);

   always @(posedge clock)
   begin
      if (sys_rst)
         stepAccum <= 23'h000000;
      else if (clockEnable)
      begin
         if (stepTick)
            stepAccum <= stepSum - STEP_LIMIT;
         else
            stepAccum <= stepSum;
      end
   end

   // ****************************************************************
   // Duty computation.
   // ****************************************************************
   reg [5:0] phaseATableIndex;
   reg [5:0] phaseBTableIndex;
   reg [5:0] phaseCTableIndex;
   wire [7:0] freqRef = speedRef[9:2];
   wire [7:0] sampleA = sineTable[phaseATableIndex];
   wire [7:0] sampleB = sineTable[phaseBTableIndex];
   wire [7:0] sampleC = sineTable[phaseCTableIndex];
   wire [15:0] productA = sampleA * freqRef;
   wire [15:0] productB = sampleB * freqRef;
   wire [15:0] productC = sampleC * freqRef;
   wire [7:0] newDutyA = (sampleA == 8'h00) ? 8'h00 : productA[15:8];
   wire [7:0] newDutyB = (sampleB == 8'h00) ? 8'h00 : productB[15:8];
   wire [7:0] newDutyC = (sampleC == 8'h00) ? 8'h00 : productC[15:8];

   function [5:0] nextIndex;
      input [5:0] idx;
      begin
         if (idx >= `VFPWM_TABLE_LAST)
            nextIndex = 6'h00;
         else
            nextIndex = idx + 6'h01;
      end
   endfunction

   // ****************************************************************
   // Register file.
   // ****************************************************************
   reg [1:0] ctrl;
   reg [7:0] pwmPeriodLimit;
   reg faultSticky;
   reg [7:0] phaseADutyHold;
   reg [7:0] phaseBDutyHold;
   reg [7:0] phaseCDuty;
   wire forward = ctrl[`VFPWM_CTRL_FORWARD];
   wire faultNow = ~faultSync_n;

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         ctrl <= `VFPWM_CTRL_RESET;
         pwmPeriodLimit <= `VFPWM_PERIOD_RESET;
         faultSticky <= 1'b0;
         regReadData <= 16'h0000;
      end
      else if (clockEnable)
      begin
         if (regWrite && regAddr == `VFPWM_ADDR_CTRL)
            ctrl <= regWriteData[1:0];
         if (regWrite && regAddr == `VFPWM_ADDR_PERIOD)
            pwmPeriodLimit <= regWriteData[7:0];
         // A fault present in the clearing cycle keeps the flag set.
         if (faultNow)
            faultSticky <= 1'b1;
         else if (regWrite && regAddr == `VFPWM_ADDR_STATUS &&
            regWriteData[`VFPWM_STAT_FAULT_STICKY])
            faultSticky <= 1'b0;
         if (regRead)
         begin
            case (regAddr)
               `VFPWM_ADDR_CTRL: regReadData <= {14'h0000, ctrl};
               `VFPWM_ADDR_PERIOD: regReadData <= {8'h00, pwmPeriodLimit};
               `VFPWM_ADDR_STATUS:
                  regReadData <= {13'h0000, directionIndicator, faultNow, faultSticky};
               `VFPWM_ADDR_SPEED: regReadData <= {6'h00, speedRef};
               `VFPWM_ADDR_DUTY_AB: regReadData <= {phaseBDutyHold, phaseADutyHold};
               `VFPWM_ADDR_DUTY_C: regReadData <= {8'h00, phaseCDuty};
               default: regReadData <= 16'h0000;
            endcase
         end
         else
            regReadData <= 16'h0000;
      end
   end

   assign driverEnable = ctrl[`VFPWM_CTRL_ENABLE];

   // ****************************************************************
   // Duty load and table advance on step overflow.
   // ****************************************************************
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         phaseATableIndex <= `VFPWM_OFFSET_A_RESET;
         phaseBTableIndex <= `VFPWM_OFFSET_B_RESET;
         phaseCTableIndex <= `VFPWM_OFFSET_C_RESET;
         phaseADutyHold <= 8'h00;
         phaseBDutyHold <= 8'h00;
         phaseCDuty <= 8'h00;
         directionIndicator <= 1'b0;
      end
      else if (clockEnable && stepTick)
      begin
         if (forward)
         begin
            phaseADutyHold <= newDutyA;
            phaseBDutyHold <= newDutyB;
            directionIndicator <= 1'b1;
         end
         else
         begin
            phaseADutyHold <= newDutyB;
            phaseBDutyHold <= newDutyA;
            directionIndicator <= 1'b0;
         end
         phaseCDuty <= newDutyC;
         phaseATableIndex <= nextIndex(phaseATableIndex);
         phaseBTableIndex <= nextIndex(phaseBTableIndex);
         phaseCTableIndex <= nextIndex(phaseCTableIndex);
      end
   end

   // ****************************************************************
   // PWM period timer and counter-compare channels.
   // ****************************************************************
   reg [7:0] pwmPeriodTimer;
   wire periodMatch = (pwmPeriodTimer >= pwmPeriodLimit);

   always @(posedge clock)
   begin
      if (sys_rst)
         pwmPeriodTimer <= 8'h00;
      else if (clockEnable)
      begin
         if (periodMatch)
            pwmPeriodTimer <= 8'h00;
         else
            pwmPeriodTimer <= pwmPeriodTimer + 8'h01;
      end
   end

   assign phaseADrive = (pwmPeriodTimer < phaseADutyHold);
   assign phaseBDrive = (pwmPeriodTimer < phaseBDutyHold);

   // ****************************************************************
   // Phase C duty timer channel.
   // ****************************************************************
   // The timer is loaded with minus the duty, so it reaches its top value
   // after duty minus one steps and the output stays high for duty cycles.
   reg [7:0] phaseCDutyTimer;

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         phaseCDutyTimer <= 8'hFF;
         phaseCDrive <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (periodMatch)
         begin
            phaseCDutyTimer <= ~phaseCDuty + 8'h01;
            phaseCDrive <= (phaseCDuty != 8'h00);
         end
         else if (phaseCDutyTimer == 8'hFF)
            phaseCDrive <= 1'b0;
         else
            phaseCDutyTimer <= phaseCDutyTimer + 8'h01;
      end
   end

endmodule // vfpwm_three_phase

// ==== vfpwm_consts.vh ====
`ifndef VFPWM_CONSTS_VH
`define VFPWM_CONSTS_VH
// ****************************************************************
// Register offsets (word index on the plain register port).
// ****************************************************************
`define VFPWM_ADDR_CTRL 3'h0
`define VFPWM_ADDR_PERIOD 3'h1
`define VFPWM_ADDR_STATUS 3'h2
`define VFPWM_ADDR_SPEED 3'h3
`define VFPWM_ADDR_DUTY_AB 3'h4
`define VFPWM_ADDR_DUTY_C 3'h5
// ****************************************************************
// Field positions.
// ****************************************************************
`define VFPWM_CTRL_ENABLE 0
`define VFPWM_CTRL_FORWARD 1
`define VFPWM_STAT_FAULT_STICKY 0
`define VFPWM_STAT_FAULT_LEVEL 1
`define VFPWM_STAT_FORWARD 2
// ****************************************************************
// Reset values.
// ****************************************************************
`define VFPWM_CTRL_RESET 2'h2
`define VFPWM_PERIOD_RESET 8'hFF
// ****************************************************************
// Sine table geometry.
// ****************************************************************
`define VFPWM_TABLE_ENTRIES 48
`define VFPWM_TABLE_LAST 6'h2F
`define VFPWM_OFFSET_A_RESET 6'h00
`define VFPWM_OFFSET_B_RESET 6'h10
`define VFPWM_OFFSET_C_RESET 6'h20
// ****************************************************************
// Timing.
// ****************************************************************
`define VFPWM_CLOCK_HZ 10000000
`define VFPWM_RESAMPLE_TIME_NS 2200000
`define VFPWM_MAX_MOTOR_HZ 60
`define VFPWM_SPEED_FULL_SCALE 1023
`endif

// ==== vfpwm_chk.sv ====
module vfpwm_chk (
   input wire clock,
   input wire sys_rst,
   input wire clockEnable,
   input wire [2:0] regAddr,
   input wire [15:0] regWriteData,
   input wire regWrite,
   input wire regRead,
   input wire [15:0] regReadData,
   input wire [9:0] speedSample,
   input wire driverFault_n,
   input wire phaseADrive,
   input wire phaseBDrive,
   input wire phaseCDrive,
   input wire driverEnable,
   input wire directionIndicator
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire rdStat = clockEnable && regRead && regAddr == 3'h2;
   AST_ENABLE_FOLLOWS: assert property (clockEnable && regWrite && regAddr == 3'h0
      |=> driverEnable == $past(regWriteData[0])) else $error("enable differs from write");
   AST_ENABLE_HOLDS: assert property (!$past(regWrite) |-> $stable(driverEnable))
      else $error("enable moved without a write");
   AST_SPEED_TEN_BITS: assert property (clockEnable && regRead && regAddr == 3'h3
      |=> regReadData[15:10] == 6'h00) else $error("speed wider than ten bits");
   AST_FAULT_SEEN: assert property (!driverFault_n [*4] ##0 rdStat
      |=> regReadData[1:0] == 2'h3) else $error("fault not reported");
   AST_FAULT_GONE: assert property (driverFault_n [*4] ##0 rdStat
      |=> !regReadData[1]) else $error("fault level stuck");
   AST_DIR_STATUS: assert property (rdStat |=> regReadData[2] == $past(directionIndicator))
      else $error("direction status differs from indicator");
   AST_PERIOD_BACK: assert property (clockEnable && regWrite && regAddr == 3'h1
      ##2 clockEnable && regRead && regAddr == 3'h1
      |=> regReadData == {8'h00, $past(regWriteData[7:0], 3)}) else $error("period readback");
   AST_DUTY_C_BYTE: assert property (clockEnable && regRead && regAddr == 3'h5
      |=> regReadData[15:8] == 8'h00) else $error("phase c duty wider than a byte");
   COV_FAULT: cover property (!driverFault_n [*4] ##0 rdStat);
   COV_PHASE_C: cover property ($rose(phaseCDrive));
   COV_REVERSE: cover property ($fell(directionIndicator));
endmodule // vfpwm_chk

bind vfpwm_three_phase vfpwm_chk u_chk (.clock(clock), .sys_rst(sys_rst),
   .clockEnable(clockEnable), .regAddr(regAddr), .regWriteData(regWriteData),
   .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
   .speedSample(speedSample), .driverFault_n(driverFault_n), .phaseADrive(phaseADrive),
   .phaseBDrive(phaseBDrive), .phaseCDrive(phaseCDrive), .driverEnable(driverEnable),
   .directionIndicator(directionIndicator));

// ==== vfpwm_gate_drv.sv ====
module vfpwm_gate_drv #(
   parameter int RETRY_NS = 2000
)(
   input wire logic [2:0] phaseDrive,
   input wire logic driverEnable,
   input wire logic overCurrent,
   input wire logic underVoltage,
   output logic [2:0] highGate,
   output logic [2:0] lowGate,
   output logic driverFault_n
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [2:0] lagged;
   logic overCurrentFault = 1'b0;
   wire run = driverEnable && driverFault_n;
   assign #200 lagged = phaseDrive;
   assign highGate = run ? (phaseDrive & lagged) : 3'h0;
   assign lowGate = run ? (~phaseDrive & ~lagged) : 3'h0;
   assign driverFault_n = !(overCurrentFault || underVoltage);
   always @(posedge overCurrent)
   begin
      overCurrentFault = 1'b1;
      #RETRY_NS;
      while (overCurrent)
         #RETRY_NS;
      overCurrentFault = 1'b0;
   end
endmodule // vfpwm_gate_drv

// ==== vfpwm_tb.sv ====
`include "vfpwm_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [15:0] regWriteData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic clockEnable = 1'b1;
   logic [9:0] speedSample = 10'h000;
   logic overCurrent = 1'b0;
   wire [15:0] regReadData;
   wire phaseADrive, phaseBDrive, phaseCDrive, driverEnable, directionIndicator, driverFault_n;
   int mismatches = 0;
   int compares = 0;
   logic [15:0] d;
   logic [15:0] h;
   vfpwm_three_phase #(.STEP_THRESHOLD(102300), .RESAMPLE_CYCLES(20)) DUT (.clock(clock),
      .sys_rst(sys_rst), .clockEnable(clockEnable), .regAddr(regAddr),
      .regWriteData(regWriteData),
      .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
      .speedSample(speedSample), .driverFault_n(driverFault_n), .phaseADrive(phaseADrive),
      .phaseBDrive(phaseBDrive), .phaseCDrive(phaseCDrive), .driverEnable(driverEnable),
      .directionIndicator(directionIndicator));
   vfpwm_gate_drv u_drv (.phaseDrive({phaseCDrive, phaseBDrive, phaseADrive}),
      .driverEnable(driverEnable), .overCurrent(overCurrent), .underVoltage(1'b0),
      .highGate(), .lowGate(), .driverFault_n(driverFault_n));
   // ****************************************************************
   // Bus tasks and checks.
   // ****************************************************************
   initial forever #50 clock = ~clock;
   task summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task doReset;
      sys_rst <= 1'b1;
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
   endtask
   task wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= v;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [2:0] a, output logic [15:0] v);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      @(posedge clock);
      v = regReadData;
   endtask
   task waitTick(output logic [15:0] v);
      int n;
      v = 16'h0000;
      for (n = 0; n < 3000 && v === 16'h0000; n++) rd(3'h4, v);
      if (v === 16'h0000)
      begin
         $display("Error tick wait expected tick seen none");
         mismatches++;
         summarize();
      end
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task testRegs;
      chk("indicator", 16'h0000, {15'h0000, directionIndicator});
      rd(3'h0, d);
      chk("ctrl", 16'h0002, d);
      rd(3'h1, d);
      chk("period", 16'h00FF, d);
      rd(3'h6, d);
      chk("unmapped", 16'h0000, d);
      wr(3'h3, 16'h03FF);
      rd(3'h3, d);
      chk("speed", 16'h0000, d);
      wr(3'h0, 16'h0003);
      @(posedge clock);
      chk("enable", 16'h0001, {15'h0000, driverEnable});
      $display("test regs done");
   endtask
   task testForward;
      speedSample <= 10'h3FF;
      d = 16'h0000;
      waitTick(d);
      chk("dutyA", 16'h007F, {8'h00, d[7:0]});
      chk("indicator", 16'h0001, {15'h0000, directionIndicator});
      repeat (40) @(posedge clock);
      rd(3'h4, h);
      chk("dutyHold", 16'hEE7F, h);
      repeat (400) @(posedge clock);
      rd(3'h5, d);
      chk("dutyC", 16'h0000, d);
      repeat (4400) @(posedge clock);
      rd(3'h4, d);
      chk("dutyWrap", 16'h007F, {8'h00, d[7:0]});
      rd(3'h3, d);
      chk("speed", 16'h03FF, d);
      $display("test forward done");
   endtask
   task testFault;
      overCurrent <= 1'b1;
      repeat (6) @(posedge clock);
      rd(3'h2, d);
      chk("faultSet", 16'h0003, {14'h0000, d[1:0]});
      wr(3'h2, 16'h0001);
      rd(3'h2, d);
      chk("faultSetWins", 16'h0003, {14'h0000, d[1:0]});
      overCurrent <= 1'b0;
      repeat (30) @(posedge clock);
      wr(3'h2, 16'h0001);
      rd(3'h2, d);
      chk("faultClear", 16'h0000, {14'h0000, d[1:0]});
      $display("test fault done");
   endtask
   task testReverse;
      int cnt;
      int cntA;
      int cntB;
      int n;
      logic prev;
      speedSample <= 10'h100;
      doReset();
      wr(3'h0, 16'h0001);
      wr(3'h1, 16'h003F);
      rd(3'h1, d);
      chk("period", 16'h003F, d);
      waitTick(d);
      chk("dutyB", 16'h0020, {8'h00, d[15:8]});
      chk("dutyA", 16'h003B, {8'h00, d[7:0]});
      chk("indicator", 16'h0000, {15'h0000, directionIndicator});
      rd(3'h5, h);
      chk("dutyC", 16'h0004, h);
      cnt = 0;
      cntA = 0;
      cntB = 0;
      prev = 1'b1;
      n = 0;
      @(negedge clock);
      while (n < 200 && !(prev === 1'b0 && phaseCDrive === 1'b1))
      begin
         prev = phaseCDrive;
         @(negedge clock);
         n++;
      end
      if (prev !== 1'b0 || phaseCDrive !== 1'b1)
      begin
         $display("Error phase c rise expected edge seen none");
         mismatches++;
         summarize();
      end
      repeat (64)
      begin
         cnt += phaseCDrive;
         cntA += phaseADrive;
         cntB += phaseBDrive;
         @(negedge clock);
      end
      chk("phaseCHigh", 16'h0004, 16'(cnt));
      chk("phaseAHigh", 16'h003B, 16'(cntA));
      chk("phaseBHigh", 16'h0020, 16'(cntB));
      $display("test reverse done");
   endtask
   task testFreeze;
      @(posedge clock);
      clockEnable <= 1'b0;
      wr(3'h0, 16'h0000);
      clockEnable <= 1'b1;
      rd(3'h0, d);
      chk("frozenCtrl", 16'h0001, d);
      $display("test freeze done");
   endtask
   initial
   begin
      doReset();
      testRegs();
      testForward();
      testFault();
      testReverse();
      testFreeze();
      summarize();
   end
endmodule // tb
